// ---- shared/uart_irq_pkg.sv ----
// Constants for the serial channel interrupt, trigger and time-out logic
package uart_irq_pkg;

  // ==========================================================================
  // Register offsets on the host port
  // ==========================================================================
  localparam logic [2:0] ADDR_DATA     = 3'h0; // Read receive buffer, write tx holding
  localparam logic [2:0] ADDR_IER      = 3'h1; // interrupt_enable
  localparam logic [2:0] ADDR_IIR_FCR  = 3'h2; // Read identification, write fifo_control
  localparam logic [2:0] ADDR_CHAR_CFG = 3'h3; // Character format used for timing
  localparam logic [2:0] ADDR_LSR      = 3'h5; // line_status
  localparam logic [2:0] ADDR_MSR      = 3'h6; // Modem status

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int IER_RX_DATA   = 0; // rx_data_irq_enable
  localparam int IER_TX_EMPTY  = 1; // tx_empty_irq_enable
  localparam int IER_LINE      = 2; // line_status_irq_enable
  localparam int IER_MODEM     = 3; // modem_status_irq_enable
  localparam int FCR_ENABLE    = 0; // fifo_enable_bit
  localparam int FCR_RX_RESET  = 1; // Self-clearing receive flush
  localparam int FCR_TX_RESET  = 2; // Self-clearing transmit flush
  localparam int FCR_TRIG_LO   = 6; // Trigger field low bit
  localparam int CFG_STOP      = 2; // Second stop bit programmed
  localparam int CFG_PARITY    = 3; // Parity bit present

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [3:0] IER_RESET  = 4'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [3:0] CFG_RESET  = 4'h3;

  // ==========================================================================
  // Identification codes, bits 3..0
  // ==========================================================================
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [3:0] ID_LINE    = 4'h6;
  localparam logic [3:0] ID_RX_DATA = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hC;
  localparam logic [3:0] ID_TX_EMPT = 4'h2;
  localparam logic [3:0] ID_MODEM   = 4'h0;

  // ==========================================================================
  // Depths, trigger levels and timing counts (16x receiver or transmit clock ticks)
  // ==========================================================================
  localparam logic [4:0] FIFO_DEPTH  = 5'h10;
  localparam logic [4:0] TRIG_LVL0   = 5'h01;
  localparam logic [4:0] TRIG_LVL1   = 5'h04;
  localparam logic [4:0] TRIG_LVL2   = 5'h08;
  localparam logic [4:0] TRIG_LVL3   = 5'h0E;
  localparam logic [9:0] BIT_TICKS   = 10'h010;
  localparam logic [9:0] HALF_TICKS  = 10'h008;
  localparam logic [9:0] FIXED_BITS  = 10'h007; // Start, stop and five data bits
  localparam logic [9:0] TIMEOUT_CHR = 10'h004; // Character times before time-out

endpackage

// ---- core/char_timer.sv ----
// Tick counter that flags when a programmed number of ticks has elapsed
`timescale 1ns/100ps
module char_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Control
  input  wire logic       tick,     // 16x rate enable pulse
  input  wire logic       restart,  // Clear the count
  input  wire logic       run,      // Count only while high
  input  wire logic [9:0] limit,    // Ticks to reach
  // Result
  output logic            expired   // Level while the count has reached the limit
);

  logic [9:0] cnt_q;  // Elapsed ticks
  logic [9:0] cnt_d;  // Next count
  logic       at_lim; // Count has reached the limit

  assign at_lim  = (cnt_q >= limit);
  assign expired = run && at_lim;

  // Restart dominates; a stopped timer drops back to zero so it starts fresh
  assign cnt_d = (restart || !run) ? 10'h000 :
                 (tick && !at_lim) ? cnt_q + 10'h001 : cnt_q;

  // Counter register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ---- core/uart_irq_core.sv ----
// Interrupt, trigger and time-out logic for one serial channel
// Behaviour
// - Trigger field picks 1, 4, 8, 14 bytes
// - Data interrupt while receive count reaches trigger
// - Data ready set on push, cleared when empty
// - Time-out: data held, four idle character times
// - Time-out counted on receiver clock ticks
// - Host read clears pending time-out and timer
// - Arrival or read restarts idle timer
// - Transmit empty id; cleared by write, id read
// - Empty interrupt delayed in FIFO mode unless two bytes held
// - First empty after enable change is immediate
// - Disabled direction polled: no trigger, no time-out
// - Errors still flagged; id untouched when disabled
// - Enable bits: data, empty, line, modem
// - Enable upper bits zero; only enabled sources interrupt
// - Priority: line, data/time-out, empty, modem
// - Id bit 0 low when pending; bits encode source
// - Id bit 3 marks time-out in FIFO mode
// - Id bits 5:4 zero, 7:6 follow FIFO enable
// - Line errors interrupt; status read clears
// - Compatibility mode: held character raises data interrupt
// - Modem changes interrupt; modem status read clears
// - FIFO enable bit change flushes both FIFOs
// - Status read clears error flags
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module uart_irq_core
  import uart_irq_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Host register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Receive path events
  input  wire logic       rclk_tick,      // Receiver clock 16x enable
  input  wire logic       rx_char_done,   // Character moved into receive FIFO
  input  wire logic [7:0] rx_data,        // Top of receive FIFO
  input  wire logic [3:0] rx_errors,      // Overrun, parity, framing, break pulses
  input  wire logic       rx_fifo_err,    // Error held somewhere in the FIFO
  output logic            rx_pop,         // Host took a receive byte
  output logic            rx_flush,       // Empty the receive FIFO
  // Transmit path events
  input  wire logic       tx_baud_tick,   // Transmit 16x enable
  input  wire logic       tx_load,        // Shift register took a byte
  input  wire logic       tx_shift_idle,  // Shift register empty
  output logic            tx_push_q,      // Byte written to transmit FIFO
  output logic      [7:0] tx_data_q,      // Byte that goes with tx_push_q
  output logic            tx_flush,       // Empty the transmit FIFO
  // Modem lines
  input  wire logic [3:0] modem_lines,    // Clear-to-send, set-ready, ring, carrier
  input  wire logic [3:0] modem_delta,    // Change pulses of the same lines
  // Mode and interrupt
  output logic            fifo_mode,      // FIFOs enabled
  output logic            irq_output      // Any enabled source pending, active high
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Trigger level from the two-bit field
  function automatic logic [4:0] trig_bytes(input logic [1:0] sel);
    case (sel)
      2'b00:   trig_bytes = TRIG_LVL0;
      2'b01:   trig_bytes = TRIG_LVL1;
      2'b10:   trig_bytes = TRIG_LVL2;
      default: trig_bytes = TRIG_LVL3;
    endcase
  endfunction

  // One character time in ticks, second stop bit counted (half for 5-bit words)
  function automatic logic [9:0] char_ticks(input logic [3:0] cfg);
    logic [9:0] bits;
    logic [9:0] extra;
    bits  = FIXED_BITS + {8'h00, cfg[1:0]} + {9'h000, cfg[CFG_PARITY]};
    extra = !cfg[CFG_STOP] ? 10'h000 : (cfg[1:0] == 2'b00) ? HALF_TICKS : BIT_TICKS;
    char_ticks = (bits << 4) + extra;
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  logic [3:0] ier_q;        // interrupt_enable, private to this channel
  logic       fifo_en_q;    // fifo_enable_bit
  logic [1:0] trig_sel_q;   // Receive trigger field
  logic [3:0] cfg_q;        // Word length, stop, parity for timing
  logic [4:0] rx_count_q;   // Bytes in the receive FIFO
  logic [4:0] tx_count_q;   // Bytes in the transmit FIFO
  logic [3:0] err_q;        // Sticky line errors
  logic [3:0] mdelta_q;     // Sticky modem changes
  logic       timeout_q;    // Character time-out pending
  logic       tx_holding_empty_q;       // Transmit empty interrupt pending
  logic       tx_delay_q;   // Waiting out the delayed empty interrupt
  logic       multi_q;      // Two or more bytes held since last empty
  logic [7:0] rdata_q;      // Read data, one cycle after the strobe

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire        wr_data  = reg_wr && (reg_addr == ADDR_DATA);
  wire        wr_ier   = reg_wr && (reg_addr == ADDR_IER);
  wire        wr_fcr   = reg_wr && (reg_addr == ADDR_IIR_FCR);
  wire        wr_cfg   = reg_wr && (reg_addr == ADDR_CHAR_CFG);
  wire        rd_data  = reg_rd && (reg_addr == ADDR_DATA);
  wire        rd_iir   = reg_rd && (reg_addr == ADDR_IIR_FCR);
  wire        rd_lsr   = reg_rd && (reg_addr == ADDR_LSR);
  wire        rd_msr   = reg_rd && (reg_addr == ADDR_MSR);
  // A change of the enable bit flushes both sides
  wire        fe_change = wr_fcr && (reg_wdata[FCR_ENABLE] != fifo_en_q);
  // Other fifo_control bits only count while the enable bit is written as one
  wire        fcr_live  = wr_fcr && reg_wdata[FCR_ENABLE];
  wire        rx_clr    = fe_change || (fcr_live && reg_wdata[FCR_RX_RESET]);
  wire        tx_clr    = fe_change || (fcr_live && reg_wdata[FCR_TX_RESET]);
  // Compatibility mode behaves as a one-deep holding register
  wire [4:0]  depth     = fifo_en_q ? FIFO_DEPTH : 5'h01;
  wire        rx_inc    = rx_char_done && (rx_count_q < depth);
  wire        rx_dec    = rd_data && (rx_count_q != 5'h00);
  wire        tx_inc    = tx_push_q && (tx_count_q < depth);
  wire        tx_dec    = tx_load && (tx_count_q != 5'h00);
  wire [4:0]  trig_lvl  = trig_bytes(trig_sel_q);
  wire [9:0]  chr_ticks = char_ticks(cfg_q);

  assign rx_pop     = rd_data;
  assign rx_flush   = rx_clr;
  assign tx_flush   = tx_clr;
  assign fifo_mode  = fifo_en_q;
  assign reg_rdata  = rdata_q;

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // Enable register keeps only its low four bits; upper bits do not exist
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ier_q      <= IER_RESET;
      fifo_en_q  <= 1'b0;
      trig_sel_q <= TRIG_RESET;
      cfg_q      <= CFG_RESET;
    end else begin
      if (wr_ier) begin
        ier_q <= reg_wdata[3:0];
      end
      if (wr_fcr) begin
        fifo_en_q <= reg_wdata[FCR_ENABLE];
      end
      if (fcr_live) begin
        trig_sel_q <= reg_wdata[FCR_TRIG_LO +: 2];
      end
      if (wr_cfg) begin
        cfg_q <= reg_wdata[3:0];
      end
    end
  end

  // ==========================================================================
  // FIFO occupancy
  // ==========================================================================
  // Counts mirror the external FIFOs; a flush wins over any event that cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_count_q <= 5'h00;
      tx_count_q <= 5'h00;
    end else begin
      if (rx_clr) begin
        rx_count_q <= 5'h00;
      end else begin
        rx_count_q <= rx_count_q + {4'h0, rx_inc} - {4'h0, rx_dec};
      end
      if (tx_clr) begin
        tx_count_q <= 5'h00;
      end else begin
        tx_count_q <= tx_count_q + {4'h0, tx_inc} - {4'h0, tx_dec};
      end
    end
  end

  // Host write of the holding register goes out as a registered push
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_push_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else begin
      tx_push_q <= wr_data;
      if (wr_data) begin
        tx_data_q <= reg_wdata;
      end
    end
  end

  // ==========================================================================
  // Receive sources
  // ==========================================================================
  // Data ready is pure occupancy: set by a push, gone once the FIFO is empty
  wire data_ready = (rx_count_q != 5'h00);
  // FIFO mode uses the trigger level; compatibility mode any held character
  wire rda_src    = fifo_en_q ? (rx_count_q >= trig_lvl) : data_ready;
  wire rda_pend   = ier_q[IER_RX_DATA] && rda_src;
  // Timer only runs in FIFO interrupt mode while a character waits
  wire to_run     = fifo_en_q && ier_q[IER_RX_DATA] && data_ready;
  wire to_restart = rx_char_done || rd_data;
  wire to_exp;
  wire to_pend    = timeout_q && to_run;

  // Idle timer, measured in receiver clock ticks so it follows the baud rate
  char_timer u_rx_timer (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (rclk_tick),
    .restart (to_restart),
    .run     (to_run),
    .limit   (10'((chr_ticks << 2) & 10'h3FF)),
    .expired (to_exp)
  );

  // A host read drops a pending time-out; the read also restarts the timer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timeout_q <= 1'b0;
    end else if (!to_run || rd_data) begin
      timeout_q <= 1'b0;
    end else if (to_exp) begin
      timeout_q <= 1'b1;
    end
  end

  // Error and modem flags: a new event beats a clearing read in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      err_q    <= 4'h0;
      mdelta_q <= 4'h0;
    end else begin
      err_q    <= (rd_lsr ? 4'h0 : err_q) | rx_errors;
      mdelta_q <= (rd_msr ? 4'h0 : mdelta_q) | modem_delta;
    end
  end

  wire line_pend  = ier_q[IER_LINE] && (err_q != 4'h0);
  wire modem_pend = ier_q[IER_MODEM] && (mdelta_q != 4'h0);

  // ==========================================================================
  // Transmit empty source
  // ==========================================================================
  wire tx_empty   = (tx_count_q == 5'h00);
  // The last byte leaves and nothing new arrives in the same cycle
  wire empty_evt  = tx_dec && (tx_count_q == 5'h01) && !tx_inc;
  // Short bursts wait one character less the final stop bit before interrupting
  wire delay_now  = empty_evt && fifo_en_q && !multi_q;
  wire tx_exp;
  // Enabling the source while already empty reports at once
  wire tx_empty_irq_enable_rise  = wr_ier && reg_wdata[IER_TX_EMPTY] && !ier_q[IER_TX_EMPTY] && tx_empty;
  wire tx_holding_empty_set   = (empty_evt && !delay_now) || (tx_delay_q && tx_exp) ||
                    fe_change || tx_empty_irq_enable_rise;
  wire tx_holding_empty_pend  = ier_q[IER_TX_EMPTY] && tx_holding_empty_q;
  wire [3:0] id_w;

  // Delay timer on the transmit 16x ticks
  char_timer u_tx_timer (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (tx_baud_tick),
    .restart (delay_now),
    .run     (tx_delay_q),
    .limit   (chr_ticks - BIT_TICKS),
    .expired (tx_exp)
  );

  // Burst tracking and the pending delay
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      multi_q    <= 1'b0;
      tx_delay_q <= 1'b0;
    end else begin
      if (empty_evt || tx_clr) begin
        multi_q <= 1'b0;
      end else if (tx_count_q >= 5'h02) begin
        multi_q <= 1'b1;
      end
      if (delay_now) begin
        tx_delay_q <= 1'b1;
      end else if (tx_exp || tx_push_q || tx_clr) begin
        tx_delay_q <= 1'b0;
      end
    end
  end

  // Cleared by a holding write or by reading the id while it is the source
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_holding_empty_q <= 1'b0;
    end else if (tx_holding_empty_set) begin
      tx_holding_empty_q <= 1'b1;
    end else if (wr_data || (rd_iir && (id_w == ID_TX_EMPT))) begin
      tx_holding_empty_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Identification and interrupt output
  // ==========================================================================
  // Fixed priority; time-out shares level two with data available
  assign id_w = line_pend  ? ID_LINE    :
                rda_pend   ? ID_RX_DATA :
                to_pend    ? ID_TIMEOUT :
                tx_holding_empty_pend  ? ID_TX_EMPT :
                modem_pend ? ID_MODEM   : ID_NONE;

  wire [7:0] iir_w = {{2{fifo_en_q}}, 2'b00, id_w};
  assign irq_output = !id_w[0];

  wire [7:0] lsr_w = {rx_fifo_err && fifo_en_q, tx_empty && tx_shift_idle, tx_empty,
                      err_q[3], err_q[2], err_q[1], err_q[0], data_ready};
  wire [7:0] msr_w = {modem_lines, mdelta_q};

  // Read mux; unmapped offsets read as zero
  wire [7:0] rd_mux = (reg_addr == ADDR_DATA)     ? rx_data :
                      (reg_addr == ADDR_IER)      ? {4'h0, ier_q} :
                      (reg_addr == ADDR_IIR_FCR)  ? iir_w :
                      (reg_addr == ADDR_CHAR_CFG) ? {4'h0, cfg_q} :
                      (reg_addr == ADDR_LSR)      ? lsr_w :
                      (reg_addr == ADDR_MSR)      ? msr_w : 8'h00;

  // Read data register; holds zero outside the cycle after a read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_trigger;
    @(posedge ref_clk) disable iff (!resetn)
    (fifo_en_q && ier_q[IER_RX_DATA] && !line_pend && rx_count_q >= trig_lvl)
      |-> (id_w == ID_RX_DATA);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger not reported");

  property p_ready;
    @(posedge ref_clk) disable iff (!resetn)
    (rx_char_done && !rx_clr && !rd_data) |=> data_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("data ready not set");

  property p_to_clear;
    @(posedge ref_clk) disable iff (!resetn)
    (timeout_q && rd_data) |=> !timeout_q ##1 !timeout_q;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("time-out survived read");

  property p_polled;
    @(posedge ref_clk) disable iff (!resetn)
    !ier_q[IER_RX_DATA] |-> (id_w != ID_TIMEOUT) && (id_w != ID_RX_DATA);
  endproperty
  a_polled: assert property (p_polled) else $error("polled side reported");

  property p_tx_holding_empty_wr;
    @(posedge ref_clk) disable iff (!resetn)
    (wr_data && !tx_holding_empty_set) |=> !tx_holding_empty_q;
  endproperty
  a_tx_holding_empty_wr: assert property (p_tx_holding_empty_wr) else $error("empty id not cleared");

  property p_ier_read;
    @(posedge ref_clk) disable iff (!resetn)
    (reg_rd && reg_addr == ADDR_IER) |=> (reg_rdata[7:4] == 4'h0);
  endproperty
  a_ier_read: assert property (p_ier_read) else $error("enable upper bits set");

  property p_line_first;
    @(posedge ref_clk) disable iff (!resetn)
    line_pend |-> (iir_w[3:0] == ID_LINE) && irq_output;
  endproperty
  a_line_first: assert property (p_line_first) else $error("line status not first");

  property p_iir_top;
    @(posedge ref_clk) disable iff (!resetn)
    rd_iir |=> (reg_rdata[7:4] == {{2{$past(fifo_en_q)}}, 2'b00});
  endproperty
  a_iir_top: assert property (p_iir_top) else $error("id upper bits wrong");

  property p_lsr_clear;
    @(posedge ref_clk) disable iff (!resetn)
    (rd_lsr && rx_errors == 4'h0) |=> (err_q == 4'h0);
  endproperty
  a_lsr_clear: assert property (p_lsr_clear) else $error("errors not cleared");

  property p_flush;
    @(posedge ref_clk) disable iff (!resetn)
    fe_change |=> (rx_count_q == 5'h00) && (tx_count_q == 5'h00) && tx_holding_empty_q;
  endproperty
  a_flush: assert property (p_flush) else $error("enable change did not flush");

endmodule

// ---- test/far_side_model.sv ----
// Far-side model: external receive FIFO and transmit shift register
`timescale 1ns/100ps
module far_side_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Bench request
  input  wire logic       put_req,      // Load put_byte as a new character
  input  wire logic [7:0] put_byte,
  // Core side
  input  wire logic       rx_pop,
  input  wire logic       rx_flush,
  input  wire logic       tx_push_q,
  output logic            rx_char_done,
  output logic      [7:0] rx_data,
  output logic            tx_load
);
  // ==========================================================================
  // Storage
  // ==========================================================================
  logic [7:0] mem [32];   // Byte store, pointers wrap
  logic [4:0] rd_q;       // Oldest byte
  logic [4:0] wr_q;       // Next free place
  logic [7:0] last_q;     // Last byte shown
  // Empty FIFO shows the inverse of the last byte, so a stale read cannot pass
  assign rx_data = (rd_q != wr_q) ? mem[rd_q] : ~last_q;
  // Push, pop and flush; the shift register is always idle and takes a byte the cycle after each push
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= 5'h00;
      wr_q <= 5'h00;
      last_q <= 8'h00;
      rx_char_done <= 1'b0;
      tx_load <= 1'b0;
    end else begin
      if (rx_flush) begin
        rd_q <= wr_q;
      end else if (rx_pop && rd_q != wr_q) begin
        last_q <= mem[rd_q];
        rd_q <= rd_q + 5'h01;
      end
      if (put_req) begin
        mem[wr_q] <= put_byte;
        wr_q <= wr_q + 5'h01;
      end
      rx_char_done <= put_req;
      tx_load <= tx_push_q;
    end
  end
endmodule

// ---- test/uart_irq_core_test.sv ----
// Self-checking bench for the serial channel interrupt logic
`timescale 1ns/100ps
module uart_irq_core_test;
  import uart_irq_pkg::*;
  // ==========================================================================
  // Signals and bookkeeping
  // ==========================================================================
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [3:0] rx_errors = 4'h0;
  logic [3:0] modem_delta = 4'h0;
  logic       put_req = 1'b0;
  logic [7:0] put_byte = 8'h00;
  logic [7:0] reg_rdata, rx_data;
  logic       rx_char_done, rx_pop, rx_flush, tx_push_q, tx_load, rd_pend = 1'b0;
  logic [7:0] tx_data_q;    // Byte handed to the transmit FIFO
  logic       fifo_mode, irq_output, rclk_tick = 1'b0;
  logic [15:0] exp_v;
  logic [15:0] exp_q [$];   // Pending reads: mask and value
  logic [7:0]  held [$];    // Bytes now in the receive FIFO
  int n_errors = 0;
  int checks_done = 0;
  int seed = 69650;
  int cycles = 0;
  // Free-running 125 MHz clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  uart_irq_core dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rclk_tick(rclk_tick), .rx_char_done(rx_char_done), .rx_data(rx_data),
    .rx_errors(rx_errors), .rx_fifo_err(1'b0), .rx_pop(rx_pop), .rx_flush(rx_flush),
    .tx_baud_tick(1'b1), .tx_load(tx_load), .tx_shift_idle(1'b1), .tx_push_q(tx_push_q),
    .tx_data_q(tx_data_q), .tx_flush(), .modem_lines(4'h0), .modem_delta(modem_delta),
    .fifo_mode(fifo_mode), .irq_output(irq_output));
  far_side_model far (.ref_clk(ref_clk), .resetn(resetn), .put_req(put_req),
    .put_byte(put_byte), .rx_pop(rx_pop), .rx_flush(rx_flush), .tx_push_q(tx_push_q),
    .rx_char_done(rx_char_done), .rx_data(rx_data), .tx_load(tx_load));
  // ==========================================================================
  // Bus tasks; a gap cycle keeps each strobe assigned once per time step
  // ==========================================================================
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic ev(input logic [3:0] e, input logic [3:0] m);
    rx_errors <= e;
    modem_delta <= m;
    @(posedge ref_clk);
    rx_errors <= 4'h0;
    modem_delta <= 4'h0;
    @(posedge ref_clk);
  endtask
  task automatic put;
    logic [31:0] r;
    r = $random(seed);
    held.push_back(r[7:0]);
    put_byte <= r[7:0];
    put_req <= 1'b1;
    @(posedge ref_clk);
    put_req <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Level outputs, looked at mid-cycle: {fifo_mode, irq_output, tx_data_q}
  task automatic chk_out(input logic [9:0] e);
    @(negedge ref_clk);
    checks_done++;
    if ({fifo_mode, irq_output, tx_data_q} !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h want %h", $time, {fifo_mode, irq_output, tx_data_q}, e);
    end
    @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Read data stand one cycle after the strobe; compare with the oldest note
  always @(posedge ref_clk) rd_pend <= reg_rd;
  // Receiver clock at half rate, so time-out timing differs from the system clock
  always @(posedge ref_clk) rclk_tick <= ~rclk_tick;
  always @(negedge ref_clk) begin
    if (rd_pend) begin
      exp_v = exp_q.pop_front();
      checks_done++;
      if ((reg_rdata & exp_v[15:8]) !== exp_v[7:0]) begin
        n_errors++;
        $display("BAD t=%0t got %h want %h", $time, reg_rdata & exp_v[15:8], exp_v[7:0]);
      end
    end
  end
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(ADDR_IER, 8'h00, 8'hFF);
    rd(ADDR_IIR_FCR, 8'h01, 8'hFF);
    wr(ADDR_IER, 8'hFD);
    rd(ADDR_IER, 8'h0D, 8'hFF);
    ev(4'h0, 4'h1);
    rd(ADDR_IIR_FCR, 8'h00, 8'hFF);
    chk_out(10'h100);
    put();
    rd(ADDR_IIR_FCR, 8'h04, 8'hFF);
    ev(4'h2, 4'h0);
    rd(ADDR_IIR_FCR, 8'h06, 8'hFF);
    rd(ADDR_LSR, 8'h05, 8'h1F);
    rd(ADDR_IIR_FCR, 8'h04, 8'hFF);
    rd(ADDR_DATA, held.pop_front(), 8'hFF);
    rd(ADDR_IIR_FCR, 8'h00, 8'hFF);
    rd(ADDR_MSR, 8'h01, 8'h0F);
    rd(ADDR_IIR_FCR, 8'h01, 8'hFF);
    $display("compatibility mode test done");
    wr(ADDR_IIR_FCR, 8'hC1);
    wr(ADDR_IER, 8'h03);
    rd(ADDR_IIR_FCR, 8'hC2, 8'hFF);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    wr(ADDR_DATA, 8'h5A);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    repeat (200) @(posedge ref_clk);
    rd(ADDR_IIR_FCR, 8'hC2, 8'hFF);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    $display("transmit empty test done");
    wr(ADDR_CHAR_CFG, 8'h07);
    repeat (14) put();
    rd(ADDR_IIR_FCR, 8'hC4, 8'hFF);
    rd(ADDR_DATA, held.pop_front(), 8'hFF);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    repeat (1330) @(posedge ref_clk);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    repeat (100) @(posedge ref_clk);
    rd(ADDR_IIR_FCR, 8'hCC, 8'hFF);
    chk_out(10'h35A);
    rd(ADDR_DATA, held.pop_front(), 8'hFF);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    wr(ADDR_IER, 8'h00);
    repeat (1500) @(posedge ref_clk);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    chk_out(10'h25A);
    ev(4'h1, 4'h0);
    rd(ADDR_IIR_FCR, 8'hC1, 8'hFF);
    rd(ADDR_LSR, 8'h03, 8'h03);
    rd(ADDR_LSR, 8'h01, 8'h01);
    $display("receive trigger and time-out test done");
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end
endmodule
